// ### design/formatter_select_arbiter_cfg.svh
// offsets, field positions, microcode codes and timing counts of the arbiter
`ifndef FORMATTER_SELECT_ARBITER_CFG_SVH
`define FORMATTER_SELECT_ARBITER_CFG_SVH

`define FSA_CLK_NS         50
`define FSA_CLK_MHZ        20
`define FSA_PHASE_NS       130
`define FSA_PULSE_NS       70
`define FSA_PHASE_CYC      ((`FSA_PHASE_NS + `FSA_CLK_NS - 1) / `FSA_CLK_NS)
`define FSA_PULSE_CYC      (`FSA_PULSE_NS / `FSA_CLK_NS)
`define FSA_PERIOD_CYC     (`FSA_PHASE_CYC + `FSA_PULSE_CYC)
`define FSA_REQ_REL_US     5
`define FSA_FORCE_REL_US   100
`define FSA_REQ_REL_CYC    (`FSA_REQ_REL_US * `FSA_CLK_MHZ)
`define FSA_FORCE_REL_CYC  (`FSA_FORCE_REL_US * `FSA_CLK_MHZ)

`define FSA_ADDR_DIRECTOR  8'h00
`define FSA_ADDR_STATUS    8'h04
`define FSA_ADDR_ROM_ADDR  8'h08
`define FSA_ADDR_ROM_DATA  8'h0c
`define FSA_ADDR_SEQ       8'h10
`define FSA_ADDR_MIR       8'h14

`define FSA_DIR_CLEAR_BIT  0
`define FSA_DIR_SELECT_BIT 1
`define FSA_DIR_RELEASE_BIT 6
`define FSA_DIR_REQREL_BIT 7
`define FSA_DIR_FORCE_BIT  8
`define FSA_STAT_ERR_BIT   4

`define FSA_MODE_CLEAR     2'h2
`define FSA_MODE_SET       2'h3
`define FSA_CTL_CUERR      5'h04
`define FSA_CTL_NEED       5'h05
`define FSA_COND_TRUE      0
`define FSA_COND_PARITY    9
`define FSA_COND_ALARM     14
`define FSA_COND_SELECTED  16

`define FSA_RESP_OKAY      2'h0
`define FSA_RESP_SLVERR    2'h2
`define FSA_ROM_DEPTH      512

`endif

// ### design/formatter_select_arbiter_pkg.sv
// types shared by the formatter select arbiter
package formatter_select_arbiter_pkg;
	typedef struct packed {
		logic       jump_when_true;
		logic [4:0] cond;
		logic [1:0] mode;
		logic [6:0] sdf;
		logic       page;
		logic [7:0] jaddr;
	} microinstr_s;

	typedef struct packed {
		logic force_release_bit;
		logic request_release;
		logic release_control_bit;
		logic unit_select;
		logic clear_if;
	} director_s;

	typedef struct packed {
		logic sel_in;
		logic alt_hold;
		logic data_input;
		logic other_fault;
		logic master_clear;
		logic [8:0] bus_in;
	} pins_s;
endpackage

// ### design/formatter_select_arbiter.sv
// formatter select arbiter with micro-sequencer and axi4-lite registers
//
// Behaviour
// - unit select with formatter unselected pulses the need strobe, setting need
// - hold sets after need only while selected-in and alternate hold are low
// - formatter raises selected-in; need resets when selected-in high with hold
// - selected sets when need resets while hold is set
// - director function with release control bit releases the selection
// - clear-interface function asserts interface clear, releasing any selection
// - selected-in falling while held sets forced release, which resets hold
// - alternate hold request with formatter free blocks our hold from setting
// - selected-in forwarded to alternate interface only while hold is reset
// - a-register bit 7 drives hold-request line for 5 us
// - force-release bit drives hold-request line 100 us, ored with request
// - error flop set by micro error strobe or bus-in parity error
// - error flop ored with other faults forms alarm, testable by microcode
// - master clock free-running, stopped only while interface clear active
// - micro-cycle 200 ns: 130 ns phase then 70 ns pulse (counted as 3 + 1 clocks of 50 ns: 150 ns phase, 50 ns pulse)
// - destination strobed at leading edge of the 70 ns pulse
// - address register loads jump address or increments at pulse end
// - satisfied jump condition continues at the instruction's jump address
// - condition 0 is true; bit 23 low is sequential, high is jump
`timescale 1ns/1ps
`include "formatter_select_arbiter_cfg.svh"

module formatter_select_arbiter (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_formatter_selected_in,
	input  wire logic        i_alt_hold_request,
	input  wire logic [8:0]  i_bus_in,
	input  wire logic        i_data_input,
	input  wire logic        i_other_fault,
	input  wire logic        i_master_clear,
	output logic             o_hold_request_line,
	output logic             o_selected_passthrough_out,
	output logic             o_local_hold,
	output logic             o_alarm,
	output logic             o_interface_clear
);
	localparam int PHASE_CYC = `FSA_PHASE_CYC;
	localparam int PERIOD_CYC = `FSA_PERIOD_CYC;
	localparam int REQ_CYC = `FSA_REQ_REL_CYC;
	localparam int FORCE_CYC = `FSA_FORCE_REL_CYC;

	function automatic logic ctl_hit(
		input formatter_select_arbiter_pkg::microinstr_s m,
		input logic [1:0] mode,
		input logic [4:0] code
	);
		ctl_hit = (m.mode == mode) && (m.sdf[4:0] == code);
	endfunction

	// pin synchronisers
	formatter_select_arbiter_pkg::pins_s pins_raw, s1_q, s2_q;
	assign pins_raw = '{sel_in: i_formatter_selected_in,
		alt_hold: i_alt_hold_request, data_input: i_data_input,
		other_fault: i_other_fault, master_clear: i_master_clear,
		bus_in: i_bus_in};

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= pins_raw;
			s2_q <= s1_q;
		end
	end

	// axi4-lite slave
	logic        aw_got_q, w_got_q, aw_take, w_take, do_wr, ar_take;
	logic        aw_got_d, w_got_d, rvalid_d;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [31:0] rd_val;
	logic        rd_ok, wr_ok;

	assign aw_take = i_awvalid & o_awready;
	assign w_take = i_wvalid & o_wready;
	assign do_wr = aw_got_q & w_got_q & ~o_bvalid;
	assign aw_got_d = (aw_got_q | aw_take) & ~do_wr;
	assign w_got_d = (w_got_q | w_take) & ~do_wr;
	assign ar_take = i_arvalid & o_arready;
	assign rvalid_d = ar_take | (o_rvalid & ~i_rready);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= `FSA_RESP_OKAY;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			o_awready <= ~aw_got_d;
			o_wready <= ~w_got_d;
			if (aw_take)
				awaddr_q <= i_awaddr;
			if (w_take) begin
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp <= wr_ok ? `FSA_RESP_OKAY : `FSA_RESP_SLVERR;
			end else if (i_bready)
				o_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `FSA_RESP_OKAY;
		end else begin
			o_arready <= ~rvalid_d;
			o_rvalid <= rvalid_d;
			if (ar_take) begin
				o_rdata <= rd_val;
				o_rresp <= rd_ok ? `FSA_RESP_OKAY : `FSA_RESP_SLVERR;
			end
		end
	end

	// register decode
	logic        wr_dir, wr_stat, wr_raddr, wr_rdata;
	logic        lane0, lane1;
	formatter_select_arbiter_pkg::director_s dir_q;
	logic [8:0]  rom_addr_q;
	logic [23:0] rom [0:`FSA_ROM_DEPTH-1];
	logic [8:0]  upc_q;
	formatter_select_arbiter_pkg::microinstr_s mir_q;
	logic        need_q, hold_q, selected_q, forced_q, err_q;
	logic [31:0] status;

	assign lane0 = wstrb_q[0];
	assign lane1 = wstrb_q[1];
	assign wr_ok = (awaddr_q == `FSA_ADDR_DIRECTOR) ||
		(awaddr_q == `FSA_ADDR_STATUS) || (awaddr_q == `FSA_ADDR_ROM_ADDR) ||
		(awaddr_q == `FSA_ADDR_ROM_DATA);
	assign wr_dir = do_wr && awaddr_q == `FSA_ADDR_DIRECTOR;
	assign wr_stat = do_wr && awaddr_q == `FSA_ADDR_STATUS && lane0;
	assign wr_raddr = do_wr && awaddr_q == `FSA_ADDR_ROM_ADDR;
	assign wr_rdata = do_wr && awaddr_q == `FSA_ADDR_ROM_DATA;
	assign status = {23'h00_0000, o_interface_clear, s2_q.sel_in,
		o_hold_request_line, o_alarm, err_q, forced_q, selected_q,
		hold_q, need_q};

	always_comb begin
		rd_ok = 1'b1;
		case (i_araddr)
		`FSA_ADDR_DIRECTOR: rd_val = 32'h0000_0000;
		`FSA_ADDR_STATUS:   rd_val = status;
		`FSA_ADDR_ROM_ADDR: rd_val = {23'h00_0000, rom_addr_q};
		`FSA_ADDR_ROM_DATA: rd_val = {8'h00, rom[rom_addr_q]};
		`FSA_ADDR_SEQ:      rd_val = {23'h00_0000, upc_q};
		`FSA_ADDR_MIR:      rd_val = {8'h00, mir_q};
		default: begin
			rd_val = 32'h0000_0000;
			rd_ok = 1'b0;
		end
		endcase
	end

	// director function becomes a one-cycle pulse
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			dir_q <= '0;
		else if (wr_dir && lane0 && lane1)
			dir_q <= '{force_release_bit: wdata_q[`FSA_DIR_FORCE_BIT],
				request_release: wdata_q[`FSA_DIR_REQREL_BIT],
				release_control_bit: wdata_q[`FSA_DIR_RELEASE_BIT],
				unit_select: wdata_q[`FSA_DIR_SELECT_BIT],
				clear_if: wdata_q[`FSA_DIR_CLEAR_BIT]};
		else
			dir_q <= '0;
	end

	// control store, loaded by software
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			rom_addr_q <= 9'h000;
		else if (wr_raddr && lane0 && lane1)
			rom_addr_q <= wdata_q[8:0];
		else if (wr_rdata)
			rom_addr_q <= rom_addr_q + 9'h001;
	end

	always_ff @(posedge i_core_clk) begin
		if (wr_rdata)
			rom[rom_addr_q] <= wdata_q[23:0];
	end

	// interface clear: power-on, master clear pin or director function
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_interface_clear <= 1'b1;
		else
			o_interface_clear <= dir_q.clear_if | s2_q.master_clear;
	end

	// master clock: micro-cycle phase counter, stopped by interface clear
	logic [1:0] cyc_q;
	logic       strobe_en, step_en;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			cyc_q <= 2'h0;
		else if (o_interface_clear)
			cyc_q <= 2'h0;
		else if (cyc_q == 2'(PERIOD_CYC - 1))
			cyc_q <= 2'h0;
		else
			cyc_q <= cyc_q + 2'h1;
	end
	assign strobe_en = ~o_interface_clear && cyc_q == 2'(PHASE_CYC - 1);
	assign step_en = ~o_interface_clear && cyc_q == 2'(PERIOD_CYC - 1);

	// sequencer: fetch early, address step at the end of the pulse
	logic [31:0] cond_vec;
	logic        cond_val, jump_taken_n;
	logic        parity_err;
	assign parity_err = s2_q.data_input & ~(^s2_q.bus_in);
	always_comb begin
		cond_vec = 32'h0000_0000;
		cond_vec[`FSA_COND_TRUE] = 1'b1;
		cond_vec[`FSA_COND_PARITY] = parity_err;
		cond_vec[`FSA_COND_ALARM] = o_alarm;
		cond_vec[`FSA_COND_SELECTED] = selected_q;
	end
	assign cond_val = cond_vec[mir_q.cond];
	assign jump_taken_n = ~(mir_q.jump_when_true ? cond_val : ~cond_val);

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			upc_q <= 9'h000;
			mir_q <= '0;
		end else if (o_interface_clear) begin
			upc_q <= 9'h000;
			mir_q <= '0;
		end else begin
			if (cyc_q == 2'h0)
				mir_q <= rom[upc_q];
			if (step_en) begin
				if (!jump_taken_n)
					upc_q <= {mir_q.page, mir_q.jaddr};
				else
					upc_q <= {upc_q[8], upc_q[7:0] + 8'h01};
			end
		end
	end

	// selection flip-flops
	logic need_strobe, need_clr, hold_set, hold_clr, sel_prev_q, forced_set;
	assign need_strobe = (strobe_en &&
		ctl_hit(mir_q, `FSA_MODE_SET, `FSA_CTL_NEED)) ||
		(dir_q.unit_select && !selected_q && !hold_q);
	assign need_clr = hold_q & s2_q.sel_in;
	assign hold_set = need_q & ~s2_q.sel_in & ~s2_q.alt_hold;
	assign hold_clr = dir_q.release_control_bit | o_interface_clear |
		forced_q;
	assign forced_set = hold_q & sel_prev_q & ~s2_q.sel_in &
		~dir_q.release_control_bit;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			need_q <= 1'b0;
		else if (o_interface_clear || need_clr)
			need_q <= 1'b0;
		else if (need_strobe)
			need_q <= 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			hold_q <= 1'b0;
		else if (hold_clr)
			hold_q <= 1'b0;
		else if (hold_set)
			hold_q <= 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			selected_q <= 1'b0;
		else if (hold_clr || !hold_q)
			selected_q <= 1'b0;
		else if (need_q && need_clr)
			selected_q <= 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			forced_q <= 1'b0;
			sel_prev_q <= 1'b0;
		end else begin
			sel_prev_q <= s2_q.sel_in;
			if (forced_set)
				forced_q <= 1'b1;
			else if (need_strobe || o_interface_clear)
				forced_q <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_selected_passthrough_out <= 1'b0;
			o_local_hold <= 1'b0;
		end else begin
			o_selected_passthrough_out <= s2_q.sel_in & ~hold_q;
			o_local_hold <= hold_q;
		end
	end

	// timed hold-request pulses
	logic [6:0]  req_q, req_d;
	logic [10:0] frc_q, frc_d;
	always_comb begin
		req_d = (req_q != 7'h00) ? req_q - 7'h01 : 7'h00;
		frc_d = (frc_q != 11'h000) ? frc_q - 11'h001 : 11'h000;
		if (dir_q.request_release)
			req_d = 7'(REQ_CYC);
		if (dir_q.force_release_bit)
			frc_d = 11'(FORCE_CYC);
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			req_q <= 7'h00;
			frc_q <= 11'h000;
			o_hold_request_line <= 1'b0;
		end else begin
			req_q <= req_d;
			frc_q <= frc_d;
			o_hold_request_line <= (req_d != 7'h00) ||
				(frc_d != 11'h000);
		end
	end

	// cycles since the last pulse trigger, saturating; bounds the line
	logic [11:0] trig_age_q;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			trig_age_q <= 12'h000;
		else if (dir_q.request_release || dir_q.force_release_bit)
			trig_age_q <= 12'h001;
		else if (trig_age_q != 12'h000 && trig_age_q != 12'hfff)
			trig_age_q <= trig_age_q + 12'h001;
	end

	// controller error and alarm
	logic err_set;
	assign err_set = (strobe_en &&
		ctl_hit(mir_q, `FSA_MODE_SET, `FSA_CTL_CUERR)) || parity_err;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			err_q <= 1'b0;
		else if (err_set)
			err_q <= 1'b1;
		else if (o_interface_clear ||
			(wr_stat && wdata_q[`FSA_STAT_ERR_BIT]))
			err_q <= 1'b0;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_alarm <= 1'b0;
		else
			o_alarm <= err_set | err_q | s2_q.other_fault;
	end

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	// 8 high cycles already checked, the line is low again REQ_CYC + 1 cycles after the trigger
	localparam int REQ_TAIL = REQ_CYC - 7;

	sequence force_trig_s;
		dir_q.force_release_bit;
	endsequence
	sequence line_high8_s;
		o_hold_request_line [*8];
	endsequence

	need_set_a: assert property (
		need_strobe && !o_interface_clear && !need_clr |=> need_q)
		else $error("need not set");
	hold_gate_a: assert property (
		$rose(hold_q) |->
		$past(need_q && !s2_q.sel_in && !s2_q.alt_hold))
		else $error("hold set without gate");
	need_drop_a: assert property (
		hold_q && s2_q.sel_in |=> !need_q)
		else $error("need not reset");
	sel_set_a: assert property (
		$rose(selected_q) |-> $past(need_q) && $past(hold_q) && !need_q)
		else $error("selected set without need fall");
	release_a: assert property (
		dir_q.release_control_bit |=> !hold_q)
		else $error("release ignored");
	clear_rel_a: assert property (
		o_interface_clear |=> !hold_q && !selected_q)
		else $error("clear kept selection");
	forced_rel_a: assert property (
		$rose(forced_q) |=> !hold_q)
		else $error("forced release kept hold");
	pass_thru_a: assert property (
		##1 o_selected_passthrough_out == $past(s2_q.sel_in && !hold_q))
		else $error("passthrough");
	req_pulse_a: assert property (
		dir_q.request_release |=> line_high8_s ##REQ_TAIL
		(o_hold_request_line == (frc_q != 11'h000)))
		else $error("request pulse length");
	force_pulse_a: assert property (
		force_trig_s |=> line_high8_s)
		else $error("force pulse missing");
	force_end_a: assert property (
		trig_age_q > 12'(FORCE_CYC) |-> !o_hold_request_line)
		else $error("force pulse too long");
	err_set_a: assert property (
		parity_err |=> err_q && o_alarm)
		else $error("parity error lost");
	clk_stop_a: assert property (
		o_interface_clear |=> cyc_q == 2'h0)
		else $error("clock runs in clear");
	strobe_tm_a: assert property (
		strobe_en |=> step_en || o_interface_clear)
		else $error("strobe not before pulse end");
	seq_step_a: assert property (
		step_en && mir_q.cond == 5'h00 |=>
		upc_q == ($past(mir_q.jump_when_true) ?
		$past({mir_q.page, mir_q.jaddr}) :
		$past({upc_q[8], upc_q[7:0] + 8'h01})))
		else $error("sequencer step wrong");
	sel_hold_a: assert property (
		!hold_q |=> !selected_q)
		else $error("selected without hold");
endmodule

// ### tb/formatter_model.sv
// behavioural controller/formatter answering the local select hold
`timescale 1ns/1ps
module formatter_model (
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	input  wire logic i_local_hold,
	input  wire logic i_offer,
	input  wire logic i_drop,
	output logic      o_sel_in
);
	logic [3:0] age_q;

	// counts how long the select hold has been seen
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			age_q <= 4'h0;
		end else if (!i_local_hold || i_drop) begin
			age_q <= 4'h0;
		end else if (age_q != 4'hf) begin
			age_q <= age_q + 4'h1;
		end
	end

	// offer: free formatter busy elsewhere; drop: fault mid-operation
	assign o_sel_in = i_offer | ((age_q > 4'h3) & ~i_drop);
endmodule

// ### tb/tb_formatter_select_arbiter.sv
// testbench of the formatter select arbiter
`timescale 1ns/1ps
`include "formatter_select_arbiter_cfg.svh"
module tb_formatter_select_arbiter;
	logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        sel_in, alt, data_in, fault, mclr, offer, drop;
	logic [8:0]  bus_in;
	logic        hreq, pass, lhold, alarm, iclr;
	int          n_errors, tests_run, cyc, hr_cnt, clr_cnt, base;

	formatter_select_arbiter dut_u (
		.i_core_clk                 (clk),
		.i_nrst                     (nrst),
		.i_awaddr                   (awaddr),
		.i_awvalid                  (awvalid),
		.o_awready                  (awready),
		.i_wdata                    (wdata),
		.i_wstrb                    (wstrb),
		.i_wvalid                   (wvalid),
		.o_wready                   (wready),
		.o_bresp                    (bresp),
		.o_bvalid                   (bvalid),
		.i_bready                   (bready),
		.i_araddr                   (araddr),
		.i_arvalid                  (arvalid),
		.o_arready                  (arready),
		.o_rdata                    (rdata),
		.o_rresp                    (rresp),
		.o_rvalid                   (rvalid),
		.i_rready                   (rready),
		.i_formatter_selected_in    (sel_in),
		.i_alt_hold_request         (alt),
		.i_bus_in                   (bus_in),
		.i_data_input               (data_in),
		.i_other_fault              (fault),
		.i_master_clear             (mclr),
		.o_hold_request_line        (hreq),
		.o_selected_passthrough_out (pass),
		.o_local_hold               (lhold),
		.o_alarm                    (alarm),
		.o_interface_clear          (iclr)
	);

	formatter_model fm_u (
		.i_core_clk   (clk),
		.i_nrst       (nrst),
		.i_local_hold (lhold),
		.i_offer      (offer),
		.i_drop       (drop),
		.o_sel_in     (sel_in)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic wrap_up();
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// cycle ceiling, pulse-length and clear-pulse counters
	always @(posedge clk) begin
		cyc++;
		if (hreq === 1'b1)
			hr_cnt++;
		if (iclr === 1'b1)
			clr_cnt++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] e,
			input logic [31:0] got);
		tests_run++;
		if (got !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ready is sampled at the falling edge, as the next rising edge sees it
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		logic pa, pw, ta, tw;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa & awready;
			tw = pw & wready;
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		axr(`FSA_ADDR_STATUS, rd, rs);
		chk("status", e, rd & m);
	endtask

	task automatic dir(input logic [31:0] d, input int n);
		axw(`FSA_ADDR_DIRECTOR, d, rs);
		tick(n);
	endtask

	initial begin
		int i;
		{nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{alt, data_in, fault, mclr, offer, drop} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		bus_in = 9'h100;
		tick(16);
		nrst <= 1'b1;
		tick(2);
		// program: 0 jumps to 5, 5 steps on, 6 loops on itself
		axw(`FSA_ADDR_ROM_ADDR, 32'h0, rs);
		for (i = 0; i < `FSA_ROM_DEPTH; i++)
			axw(`FSA_ADDR_ROM_DATA, (i == 0) ? 32'h800005 :
				((i == 6) ? 32'h800006 : 32'h0), rs);
		axw(`FSA_ADDR_ROM_ADDR, 32'h0, rs);
		axr(`FSA_ADDR_ROM_DATA, rd, rs);
		chk("rom word", 32'h800005, rd);
		mclr <= 1'b1;
		tick(10);
		chk("iface clear", 32'h1, {31'h0, iclr});
		axr(`FSA_ADDR_SEQ, rd, rs);
		chk("seq stopped", 32'h0, rd);
		mclr <= 1'b0;
		tick(40);
		axr(`FSA_ADDR_SEQ, rd, rs);
		chk("seq addr", 32'h6, rd);
		axr(`FSA_ADDR_MIR, rd, rs);
		chk("mir", 32'h800006, rd);
		axr(8'h18, rd, rs);
		chk("rresp", {30'h0, `FSA_RESP_SLVERR}, {30'h0, rs});
		chk("rdata", 32'h0, rd);
		axw(8'h18, 32'h2, rs);
		chk("bresp", {30'h0, `FSA_RESP_SLVERR}, {30'h0, rs});
		offer <= 1'b1;
		dir(32'h2, 10);
		chk("pass", 32'h1, {31'h0, pass});
		stat(32'h8f, 32'h81);
		offer <= 1'b0;
		alt <= 1'b1;
		tick(10);
		stat(32'h8f, 32'h01);
		alt <= 1'b0;
		tick(20);
		stat(32'h8f, 32'h86);
		chk("pass", 32'h0, {31'h0, pass});
		chk("local hold", 32'h1, {31'h0, lhold});
		dir(32'h40, 10);
		stat(32'h8f, 32'h00);
		dir(32'h2, 20);
		stat(32'h8f, 32'h86);
		drop <= 1'b1;
		tick(10);
		stat(32'h8f, 32'h08);
		drop <= 1'b0;
		dir(32'h2, 20);
		stat(32'h8f, 32'h86);
		base = clr_cnt;
		dir(32'h1, 10);
		chk("clear seen", 32'h1, {31'h0, clr_cnt > base});
		stat(32'h8f, 32'h00);
		// word 6 becomes set-need, then set-error, then the plain loop
		axw(`FSA_ADDR_ROM_ADDR, 32'h6, rs);
		axw(`FSA_ADDR_ROM_DATA, 32'h830a06, rs);
		tick(30);
		stat(32'h8f, 32'h86);
		axw(`FSA_ADDR_ROM_ADDR, 32'h6, rs);
		axw(`FSA_ADDR_ROM_DATA, 32'h830806, rs);
		tick(8);
		stat(32'h30, 32'h30);
		axw(`FSA_ADDR_ROM_ADDR, 32'h6, rs);
		axw(`FSA_ADDR_ROM_DATA, 32'h800006, rs);
		tick(8);
		axw(`FSA_ADDR_STATUS, 32'h10, rs);
		dir(32'h40, 10);
		stat(32'hbf, 32'h00);
		base = hr_cnt;
		dir(32'h80, 150);
		chk("req pulse", `FSA_REQ_REL_CYC, hr_cnt - base);
		base = hr_cnt;
		dir(32'h100, 2100);
		chk("force pulse", `FSA_FORCE_REL_CYC, hr_cnt - base);
		data_in <= 1'b1;
		bus_in <= 9'h000;
		tick(6);
		data_in <= 1'b0;
		stat(32'h30, 32'h30);
		chk("alarm", 32'h1, {31'h0, alarm});
		axw(`FSA_ADDR_STATUS, 32'h10, rs);
		stat(32'h30, 32'h00);
		bus_in <= 9'h100;
		data_in <= 1'b1;
		tick(6);
		data_in <= 1'b0;
		stat(32'h10, 32'h00);
		fault <= 1'b1;
		tick(6);
		chk("alarm", 32'h1, {31'h0, alarm});
		fault <= 1'b0;
		tick(6);
		chk("alarm", 32'h0, {31'h0, alarm});
		wrap_up();
	end
endmodule
